// [logic/tepc_counter.sv]
// Purpose: 8-bit timer, event counter and pulse width capture block
// Assumes: Synchronous pin inputs; clock sources given as enable pulses
// Notes:   Reads of count and reload writes inhibit one count tick
`timescale 1ns/100ps
module tepc_counter #(
	parameter int PSC_WIDTH = tepc_pkg::PSC_WIDTH
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       system_clock,
	input  wire logic       sub_clock,
	input  wire logic       event_input_pin,
	input  wire logic       sleep_mode,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	output logic      [7:0] rdata,
	output logic            overflow_irq,
	output logic            wake_request
);
	typedef enum logic [1:0] {
		CAP_IDLE,
		CAP_ARMED,
		CAP_RUN
	} tepc_cap_e;

	logic [7:0] ctrl_ff;
	logic [7:0] count_ff;
	logic [7:0] reload_ff;
	logic [7:0] rdata_ff;
	logic       flag_ff;
	logic       wake_ff;
	logic       irq_ff;
	logic       pin_ff;
	logic       edge_ff;
	logic       nxt_flag;
	tepc_cap_e  cap_ff;
	tepc_cap_e  nxt_cap;
	logic [1:0] mode;
	logic       enable;
	logic       src_tick;
	logic       tp_tick;
	logic       inhibit;
	logic       pin_rise;
	logic       pin_fall;
	logic       pin_active_edge;
	logic       pin_end_edge;
	logic       count_tick;
	logic       overflow;
	logic       cap_done;
	logic       wr_ctrl;
	logic       wr_reload;
	logic       wr_status;

	assign mode     = ctrl_ff[tepc_pkg::POS_MODE +: 2];
	assign enable   = ctrl_ff[tepc_pkg::POS_EN];
	assign wr_ctrl  = wr_stb && (addr == tepc_pkg::ADDR_CTRL);
	assign wr_reload = wr_stb && (addr == tepc_pkg::ADDR_COUNT || addr == tepc_pkg::ADDR_RELOAD);
	assign wr_status = wr_stb && (addr == tepc_pkg::ADDR_STATUS);

	// Clock source choice
	assign src_tick = ctrl_ff[tepc_pkg::POS_SRC] ? sub_clock : system_clock;

	tepc_prescaler #(
		.WIDTH(PSC_WIDTH)
	) u_prescaler (
		.mclk           (mclk),
		.rst_n          (rst_n),
		.ce             (ce),
		.src_tick       (src_tick),
		.prescale_select(ctrl_ff[tepc_pkg::POS_PSC +: 3]),
		.div_tick       (tp_tick)
	);

	assign inhibit = (rd_stb && addr == tepc_pkg::ADDR_COUNT) || wr_reload;

	// Pin edge detection against the previous sample
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_ff <= 1'b0;
		end else if (ce) begin
			pin_ff <= event_input_pin;
		end
	end

	assign pin_rise = event_input_pin && !pin_ff;
	assign pin_fall = !event_input_pin && pin_ff;

	// Edge seen in capture is held until the next timer clock pulse
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			edge_ff <= 1'b0;
		end else if (ce) begin
			if (tp_tick || cap_ff == CAP_IDLE) begin
				edge_ff <= 1'b0;
			end else if (pin_active_edge || pin_end_edge) begin
				edge_ff <= 1'b1;
			end
		end
	end

	assign pin_active_edge = ctrl_ff[tepc_pkg::POS_EDGE] ? pin_rise : pin_fall;
	assign pin_end_edge    = ctrl_ff[tepc_pkg::POS_EDGE] ? pin_fall : pin_rise;

	// Capture sequencer: start needs an active edge plus the level at the timer pulse; stop needs the level only
	always_comb begin
		nxt_cap  = cap_ff;
		cap_done = 1'b0;
		unique case (cap_ff)
			CAP_IDLE: begin
				if (mode == tepc_pkg::MODE_CAPTURE && enable) begin
					nxt_cap = CAP_ARMED;
				end
			end
			CAP_ARMED: begin
				if (!enable || mode != tepc_pkg::MODE_CAPTURE) begin
					nxt_cap = CAP_IDLE;
				end else if (tp_tick && (edge_ff || pin_active_edge)
					&& (event_input_pin == ctrl_ff[tepc_pkg::POS_EDGE])) begin
					nxt_cap = CAP_RUN;
				end
			end
			CAP_RUN: begin
				if (!enable || mode != tepc_pkg::MODE_CAPTURE) begin
					nxt_cap = CAP_IDLE;
				end else if (tp_tick
					&& (event_input_pin != ctrl_ff[tepc_pkg::POS_EDGE])) begin
					nxt_cap  = CAP_IDLE;
					cap_done = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cap_ff <= CAP_IDLE;
		end else if (ce) begin
			cap_ff <= nxt_cap;
		end
	end

	// Count tick per mode; sleep does not gate any of them
	always_comb begin
		count_tick = 1'b0;
		unique case (mode)
			tepc_pkg::MODE_TIMER: begin
				count_tick = enable && tp_tick;
			end
			tepc_pkg::MODE_EVENT: begin
				count_tick = enable && (ctrl_ff[tepc_pkg::POS_EDGE] ? pin_fall : pin_rise);
			end
			tepc_pkg::MODE_CAPTURE: begin
				count_tick = (cap_ff == CAP_RUN) && tp_tick && !cap_done;
			end
			tepc_pkg::MODE_OFF: begin
				count_tick = 1'b0;
			end
		endcase
		if (inhibit) begin
			count_tick = 1'b0;
		end
	end

	assign overflow = count_tick && (count_ff == tepc_pkg::COUNT_MAX);

	// Control register; only capture completion clears enable by hardware
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= tepc_pkg::CTRL_RESET;
		end else if (ce) begin
			if (wr_ctrl) begin
				ctrl_ff <= wdata;
			end else if (cap_done) begin
				ctrl_ff[tepc_pkg::POS_EN] <= 1'b0;
			end
		end
	end

	// Reload holding register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reload_ff <= tepc_pkg::COUNT_RESET;
		end else if (ce && wr_reload) begin
			reload_ff <= wdata;
		end
	end

	// Live counter
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count_ff <= tepc_pkg::COUNT_RESET;
		end else if (ce) begin
			if (wr_reload && !enable) begin
				count_ff <= wdata;
			end else if (overflow) begin
				count_ff <= reload_ff;
			end else if (count_tick) begin
				count_ff <= count_ff + 8'h01;
			end
		end
	end

	// Request flag: overflow wins over a software clear
	always_comb begin
		nxt_flag = flag_ff;
		if (wr_status) begin
			nxt_flag = wdata[tepc_pkg::POS_FLAG];
		end
		if (overflow) begin
			nxt_flag = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flag_ff <= 1'b0;
			irq_ff  <= 1'b0;
			wake_ff <= 1'b0;
		end else if (ce) begin
			flag_ff <= nxt_flag;
			irq_ff  <= overflow;
			wake_ff <= overflow && sleep_mode;
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 8'h00;
		end else if (ce) begin
			rdata_ff <= 8'h00;
			if (rd_stb) begin
				unique case (addr)
					tepc_pkg::ADDR_CTRL:   rdata_ff <= ctrl_ff;
					tepc_pkg::ADDR_COUNT:  rdata_ff <= count_ff;
					tepc_pkg::ADDR_STATUS: rdata_ff <= {7'h00, flag_ff};
					tepc_pkg::ADDR_RELOAD: rdata_ff <= reload_ff;
					default:               rdata_ff <= 8'h00;
				endcase
			end
		end
	end

	assign rdata        = rdata_ff;
	assign overflow_irq = irq_ff;
	assign wake_request = wake_ff;
endmodule

// [logic/tepc_pkg.sv]
// Purpose: Shared constants for the timer / event / pulse counter
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Register indices are word-aligned byte addresses
package tepc_pkg;
	localparam logic [3:0] ADDR_CTRL     = 4'h0;
	localparam logic [3:0] ADDR_COUNT    = 4'h4;
	localparam logic [3:0] ADDR_STATUS   = 4'h8;
	localparam logic [3:0] ADDR_RELOAD   = 4'hc;
	localparam int         POS_MODE      = 6;
	localparam int         POS_SRC       = 5;
	localparam int         POS_EN        = 4;
	localparam int         POS_EDGE      = 3;
	localparam int         POS_PSC       = 0;
	localparam int         POS_FLAG      = 0;
	localparam int         POS_WAKE      = 1;
	localparam logic [7:0] CTRL_RESET    = 8'h08;
	localparam logic [7:0] COUNT_RESET   = 8'h00;
	localparam logic [7:0] COUNT_MAX     = 8'hff;
	localparam logic [1:0] MODE_OFF      = 2'h0;
	localparam logic [1:0] MODE_EVENT    = 2'h1;
	localparam logic [1:0] MODE_TIMER    = 2'h2;
	localparam logic [1:0] MODE_CAPTURE  = 2'h3;
	localparam int         PSC_WIDTH     = 7;
endpackage

// [logic/tepc_prescaler.sv]
// Purpose: Power-of-two divider of the selected timer source clock
// Assumes: Source clock arrives as a one-cycle enable pulse
// Notes:   Tick marks the falling transition of the divided clock
`timescale 1ns/100ps
module tepc_prescaler #(
	parameter int WIDTH = tepc_pkg::PSC_WIDTH
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       src_tick,
	input  wire logic [2:0] prescale_select,
	output logic            div_tick
);
	logic [WIDTH-1:0] div_ff;
	logic [WIDTH:0]   nxt_div;

	assign nxt_div = {1'b0, div_ff} + {{WIDTH{1'b0}}, 1'b1};

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff <= '0;
		end else if (ce && src_tick) begin
			div_ff <= nxt_div[WIDTH-1:0];
		end
	end

	// Divided clock falls when all lower bits roll over
	always_comb begin
		if (prescale_select == 3'h0) begin
			div_tick = src_tick;
		end else begin
			div_tick = src_tick && (&(div_ff | ~((WIDTH'(1) << prescale_select) - WIDTH'(1))));
		end
	end
endmodule

// [sim/tepc_counter_asserts.sv]
// Purpose: Port checks for the counter
// Assumes: ce held high
// Notes:   Mode and enable shadowed from writes
`timescale 1ns/100ps
module tepc_chk #(
	parameter int PSC_WIDTH = tepc_pkg::PSC_WIDTH
) (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       ce,
	input wire logic       event_input_pin,
	input wire logic       sleep_mode,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_stb,
	input wire logic       rd_stb,
	input wire logic [7:0] rdata,
	input wire logic       overflow_irq,
	input wire logic       wake_request
);
	logic [1:0] mode_ff;
	logic       en_ff;
	logic [3:0] pin_ff;
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
			{mode_ff, en_ff} <= 3'b000;
		else if (ce && wr_stb && addr == 4'h0)
			{mode_ff, en_ff} <= {wdata[7:6], wdata[4]};
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
			pin_ff <= 4'h0;
		else
			pin_ff <= {pin_ff[2:0], event_input_pin};
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_off; mode_ff == 2'h0 [*3]; endsequence
	sequence s_stopped; !en_ff [*3]; endsequence
	sequence s_load;
		!en_ff && ce && wr_stb && addr == 4'h4 ##1 ce && rd_stb && addr == 4'h4;
	endsequence
	a_rdata_idle: assert property (ce && !rd_stb |=> rdata == 8'h00)
		else $error("read data outside read");
	a_unmapped_read: assert property (ce && rd_stb && addr[1:0] != 2'b00 |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_off_quiet: assert property (s_off |-> !overflow_irq)
		else $error("overflow while off");
	a_stopped_quiet: assert property (s_stopped |-> !overflow_irq)
		else $error("overflow while stopped");
	a_load_stopped: assert property (s_load |=> rdata == $past(wdata, 2))
		else $error("stopped load lost");
	a_wake_irq: assert property (wake_request |-> overflow_irq)
		else $error("wake without overflow");
	a_wake_sleep: assert property (wake_request |-> $past(sleep_mode) || $past(sleep_mode, 2))
		else $error("wake while awake");
	a_event_edge: assert property (overflow_irq && $past(mode_ff, 3) == 2'h1
		|-> pin_ff != 4'h0 && pin_ff != 4'hf) else $error("event overflow without edge");
endmodule
bind tepc_counter tepc_chk #(.PSC_WIDTH(PSC_WIDTH)) u_chk (.mclk, .rst_n, .ce, .event_input_pin,
	.sleep_mode, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .overflow_irq, .wake_request);

// [sim/tepc_counter_bench.sv]
// Purpose: Self-checking bench for the counter
// Assumes: ce high except for one short freeze
// Notes:   Expected values from an integer model
`timescale 1ns/100ps
module tepc_counter_bench;
	logic       mclk = 0, rst_n = 0, sysc = 0, subc = 0, slp = 0, wr = 0, rd = 0, ce = 1;
	logic [3:0] addr = 0;
	logic [7:0] wdata = 0, rdata, v;
	logic       irq, wake;
	wire        pin;
	int         n_fail = 0, n_tests = 0, n_irq = 0, n_wake = 0, seed = 32'h55b5, m;
	always #20 mclk = !mclk;
	always @(posedge mclk) begin
		n_irq += (irq === 1'b1);
		n_wake += (wake === 1'b1);
	end
	tepc_counter dut (.mclk, .rst_n, .ce, .system_clock(sysc), .sub_clock(subc),
		.event_input_pin(pin), .sleep_mode(slp), .addr, .wdata, .wr_stb(wr), .rd_stb(rd),
		.rdata, .overflow_irq(irq), .wake_request(wake));
	tepc_pin_src src (.mclk, .pin);
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, want, input string what);
		n_tests++;
		if (seen !== want) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic wt(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge mclk);
		wr <= 0;
	endtask
	task automatic rt(input logic [3:0] a);
		addr <= a;
		rd <= 1;
		@(posedge mclk);
		rd <= 0;
		#1 v = rdata;
		@(posedge mclk);
	endtask
	// Stop, clear flag, load count, then enable
	task automatic cfg(input logic [7:0] c, n);
		wt(4'h0, 8'h00);
		@(posedge mclk);
		wt(4'h8, 8'h00);
		@(posedge mclk);
		wt(4'h4, n);
		rt(4'h4);
		chk(v, n, "stopped load");
		wt(4'h0, c);
	endtask
	// Source pulses with noise on the unselected source
	task automatic ticks(input int k, input logic s);
		repeat (k) begin
			sysc <= !s;
			subc <= s;
			@(posedge mclk);
			sysc <= s & 1'($random(seed));
			subc <= !s & 1'($random(seed));
			repeat (1 + $unsigned($random(seed)) % 3) @(posedge mclk);
		end
		sysc <= 0;
		subc <= 0;
	endtask
	initial begin
		#800000;
		n_fail++;
		test_done();
	end
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1;
		@(posedge mclk);
		for (int i = 0; i < 5; i++) begin
			rt(4'(i * 4 + i / 4 * 2));
			chk(v, i ? 8'h00 : 8'h08, "reset value");
		end
		for (int p = 0; p < 8; p++) begin
			cfg({2'b10, p[0], 2'b10, p[2:0]}, 8'h00);
			ticks(128, p[0]);
			rt(4'h4);
			chk(v, 8'(128 >> p), "timer count");
		end
		slp <= 1;
		cfg(8'h90, 8'hfe);
		ticks(2, 0);
		rt(4'h4);
		chk(v, 8'hfe, "reloaded count");
		rt(4'h8);
		chk(v & 8'h01, 8'h01, "request flag");
		slp <= 0;
		wt(4'hc, 8'h10);
		rt(4'hc);
		chk(v, 8'h10, "reload value");
		rt(4'h4);
		chk(v, 8'hfe, "held reload");
		ticks(2, 0);
		rt(4'h4);
		chk(v, 8'h10, "applied reload");
		sysc <= 1;
		for (int e = 0; e < 2; e++) begin
			cfg({4'b0101, e[0], 3'h0}, 8'hfd);
			repeat (5) src.pulse(1, 2);
			rt(4'h4);
			chk(v, 8'hff, "event count");
			rt(4'h0);
			chk(v, {4'b0101, e[0], 3'h0}, "event enable");
		end
		// Timer on every cycle: read strobe and freeze each lose ticks
		cfg(8'h90, 8'h00);
		rt(4'h4);
		m = v;
		ce <= 0;
		repeat (5) @(posedge mclk);
		ce <= 1;
		rt(4'h4);
		chk(v, 8'(m + 1), "inhibited count");
		wt(4'h8, 8'h01);
		rt(4'h8);
		chk(v, 8'h01, "flag set before sleep");
		slp <= 1;
		for (int e = 0; e < 2; e++) begin
			src.pulse(e[0], 1);
			cfg({4'b1101, e[0], 3'h0}, 8'hf0);
			repeat (4) @(posedge mclk);
			rt(4'h4);
			chk(v, 8'hf0, "armed count");
			src.pulse(e[0], 20);
			rt(4'h4);
			m = v;
			chk(8'(m >= 'hf1 && m <= 'hf7), 8'h01, "pulse width");
			rt(4'h0);
			chk(v, {4'b1100, e[0], 3'h0}, "enable cleared");
			src.pulse(e[0], 9);
			rt(4'h4);
			chk(v, 8'(m), "count after stop");
		end
		chk(8'(n_irq), 8'h06, "overflow count");
		chk(8'(n_wake), 8'h03, "wake count");
		test_done();
	end
endmodule

// [sim/tepc_pin_src.sv]
// Purpose: External pulse and event source
// Assumes: Pin moves just after mclk edges
// Notes:   A pulse ends at the opposite level
`timescale 1ns/100ps
module tepc_pin_src (
	input wire logic mclk,
	output logic     pin
);
	initial pin = 1'b0;
	task automatic pulse(input logic lvl, input int wid);
		@(posedge mclk);
		pin <= lvl;
		repeat (wid) @(posedge mclk);
		pin <= !lvl;
		repeat (3) @(posedge mclk);
	endtask
endmodule
